// ### smt_consts.vh
`ifndef SMT_CONSTS_VH
`define SMT_CONSTS_VH

// Register offsets on the host register port
`define SMT_ADDR_MODE_CTL 8'h0A
`define SMT_ADDR_INTERVAL_HIGH 8'h0B
`define SMT_ADDR_INTERVAL_LOW 8'h0C
`define SMT_ADDR_THRESH_HIGH 8'h0D
`define SMT_ADDR_THRESH_LOW 8'h0E

// Reset values
`define SMT_RST_MODE_CTL 8'h00
`define SMT_RST_INTERVAL_HIGH 8'h80
`define SMT_RST_INTERVAL_LOW 8'h00
`define SMT_RST_THRESH_HIGH 8'h00
`define SMT_RST_THRESH_LOW 8'h00

// Field positions
`define SMT_CTL_RUN 0
`define SMT_CTL_IND_EN 1
`define SMT_CTL_MODE_HI 7
`define SMT_CTL_MODE_LO 6
`define SMT_IVH_UNIT 7

// Mode encodings of control bits 7:6
`define SMT_MODE_NORMAL1 2'b00
`define SMT_MODE_NORMAL2 2'b01
`define SMT_MODE_STANDBY1 2'b10
`define SMT_MODE_STANDBY2 2'b11

// Timing: clock period and one millisecond, both in ns
`define SMT_CLK_PERIOD_NS 4
`define SMT_MS_NS 1000000
`define SMT_MS_CYCLES (`SMT_MS_NS / `SMT_CLK_PERIOD_NS)
`define SMT_MS_PER_S 1000

`endif

// ### smt_interval_timer.v
`timescale 1ns/10ps
`include "smt_consts.vh"

module smt_interval_timer #(
  parameter MS_CYCLES = `SMT_MS_CYCLES,
  parameter MS_PER_S = `SMT_MS_PER_S
) (
  input wire ref_clk,
  input wire nrst,
  input wire run,
  input wire unit_sec,
  input wire [14:0] interval,
  output reg wake
);

  reg [17:0] pre_cnt;
  reg [9:0] ms_cnt;
  reg [14:0] unit_cnt;
  wire ms_tick;
  wire unit_tick;
  wire [14:0] last_unit;

  assign ms_tick = (pre_cnt == MS_CYCLES[17:0] - 18'h0_0001);
  // Seconds are built from millisecond ticks to share one prescaler
  assign unit_tick = ms_tick &
    (!unit_sec || (ms_cnt == MS_PER_S[9:0] - 10'h001));
  // A zero interval is treated as one unit so the wakeup never stalls
  assign last_unit = (interval == 15'h0000) ? 15'h0000
                                             : interval - 15'h0001;

  // Prescaler, unit and interval counters; all restart when idle
  always @(posedge ref_clk) begin
    if (!nrst || !run) begin
      pre_cnt <= 18'h0_0000;
      ms_cnt <= 10'h000;
      unit_cnt <= 15'h0000;
      wake <= 1'b0;
    end else begin
      wake <= 1'b0;
      pre_cnt <= ms_tick ? 18'h0_0000 : pre_cnt + 18'h0_0001;
      if (ms_tick) begin
        ms_cnt <= (unit_tick || !unit_sec) ? 10'h000 : ms_cnt + 10'h001;
      end
      if (unit_tick) begin
        if (unit_cnt >= last_unit) begin
          unit_cnt <= 15'h0000;
          wake <= 1'b1;
        end else begin
          unit_cnt <= unit_cnt + 15'h0001;
        end
      end
    end
  end

endmodule // smt_interval_timer

// ### smt_standby_regs.v
`timescale 1ns/10ps
`include "smt_consts.vh"

module smt_standby_regs #(
  parameter MS_CYCLES = `SMT_MS_CYCLES
) (
  input wire ref_clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  output reg [7:0] reg_rdata,
  output reg stopped,
  output reg [1:0] active_mode,
  output reg mode_change_indicator,
  output reg standby_wake,
  output reg interval_unit_sec,
  output reg [14:0] standby_interval,
  output reg [15:0] standby_current_threshold
);

  reg [7:0] mode_ctl;
  reg [7:0] interval_high;
  reg [7:0] interval_low;
  reg [7:0] thresh_high;
  reg [7:0] thresh_low;
  reg running;
  reg [7:0] next_rdata;
  wire in_standby;
  wire next_running;
  wire [1:0] next_mode;
  wire timer_wake;

  // Register writes from the host serial port decoder
  always @(posedge ref_clk) begin
    if (!nrst) begin
      mode_ctl <= `SMT_RST_MODE_CTL;
      interval_high <= `SMT_RST_INTERVAL_HIGH;
      interval_low <= `SMT_RST_INTERVAL_LOW;
      thresh_high <= `SMT_RST_THRESH_HIGH;
      thresh_low <= `SMT_RST_THRESH_LOW;
    end else if (reg_wr) begin
      if (reg_addr == `SMT_ADDR_MODE_CTL) begin
        mode_ctl <= reg_wdata;
      end else if (reg_addr == `SMT_ADDR_INTERVAL_HIGH) begin
        interval_high <= reg_wdata;
      end else if (reg_addr == `SMT_ADDR_INTERVAL_LOW) begin
        interval_low <= reg_wdata;
      end else if (reg_addr == `SMT_ADDR_THRESH_HIGH) begin
        thresh_high <= reg_wdata;
      end else if (reg_addr == `SMT_ADDR_THRESH_LOW) begin
        thresh_low <= reg_wdata;
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  always @* begin
    next_rdata = 8'h00;
    if (reg_addr == `SMT_ADDR_MODE_CTL) begin
      next_rdata = mode_ctl;
    end else if (reg_addr == `SMT_ADDR_INTERVAL_HIGH) begin
      next_rdata = interval_high;
    end else if (reg_addr == `SMT_ADDR_INTERVAL_LOW) begin
      next_rdata = interval_low;
    end else if (reg_addr == `SMT_ADDR_THRESH_HIGH) begin
      next_rdata = thresh_high;
    end else if (reg_addr == `SMT_ADDR_THRESH_LOW) begin
      next_rdata = thresh_low;
    end
  end

  // Mode selection only takes effect once released from STOP
  assign next_running = mode_ctl[`SMT_CTL_RUN];
  assign next_mode = mode_ctl[`SMT_CTL_MODE_HI:`SMT_CTL_MODE_LO];
  assign in_standby = running & active_mode[1];

  // Operating state and registered outputs
  always @(posedge ref_clk) begin
    if (!nrst) begin
      running <= 1'b0;
      stopped <= 1'b1;
      active_mode <= `SMT_MODE_NORMAL1;
      mode_change_indicator <= 1'b0;
      standby_wake <= 1'b0;
      interval_unit_sec <= 1'b1;
      standby_interval <= 15'h0000;
      standby_current_threshold <= 16'h0000;
      reg_rdata <= 8'h00;
    end else begin
      running <= next_running;
      stopped <= !next_running;
      // Mode is held in STOP so the last selection is visible
      if (next_running) begin
        active_mode <= next_mode;
      end
      // One pulse per standby to normal transition made without passing through STOP, if enabled
      mode_change_indicator <= mode_ctl[`SMT_CTL_IND_EN] & in_standby &
        next_running & !next_mode[1];
      standby_wake <= timer_wake & in_standby;
      interval_unit_sec <= interval_high[`SMT_IVH_UNIT];
      standby_interval <= {interval_high[6:0], interval_low};
      standby_current_threshold <= {thresh_high, thresh_low};
      reg_rdata <= next_rdata;
    end
  end

  // Interval timer runs only in a standby mode; stale count is dropped
  smt_interval_timer #(
    .MS_CYCLES(MS_CYCLES),
    .MS_PER_S(`SMT_MS_PER_S)
  ) u_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(in_standby),
    .unit_sec(interval_unit_sec),
    .interval(standby_interval),
    .wake(timer_wake)
  );

endmodule // smt_standby_regs

// ### smt_standby_regs_checker.sv
`timescale 1ns/10ps
module smt_standby_regs_checker (
  input wire ref_clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire [7:0] reg_rdata,
  input wire stopped,
  input wire [1:0] active_mode,
  input wire mode_change_indicator,
  input wire standby_wake,
  input wire interval_unit_sec,
  input wire [14:0] standby_interval,
  input wire [15:0] standby_current_threshold
);
  // One clock domain, so one default for all properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_ind;
    mode_change_indicator |-> !active_mode[1] && $past(active_mode[1]);
  endproperty
  a_ind: assert property (p_ind) else $error("stray indicator");
  property p_stop;
    stopped && $past(stopped) |-> $stable(active_mode);
  endproperty
  a_stop: assert property (p_stop) else $error("mode moved");
  property p_unit;
    reg_wr && reg_addr == 8'h0b |-> ##2 interval_unit_sec ==
      $past(reg_wdata[7], 2);
  endproperty
  a_unit: assert property (p_unit) else $error("bad unit");
  property p_low;
    reg_wr && reg_addr == 8'h0c |-> ##2 standby_interval[7:0] ==
      $past(reg_wdata, 2);
  endproperty
  a_low: assert property (p_low) else $error("bad interval");
  property p_thr;
    reg_wr && reg_addr == 8'h0d |-> ##2
      standby_current_threshold[15:8] == $past(reg_wdata, 2);
  endproperty
  a_thr: assert property (p_thr) else $error("bad threshold");
  property p_wake;
    // Mode may leave standby at the same edge as the last wake pulse
    standby_wake |-> $past(active_mode[1]) && !$past(stopped);
  endproperty
  a_wake: assert property (p_wake) else $error("stray wake");
endmodule // smt_standby_regs_checker

// ### smt_standby_regs_test.sv
`timescale 1ns/10ps
module smt_standby_regs_test;
  reg ref_clk = 0, nrst = 0, reg_wr = 0;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire stopped, ind, wake, unit;
  wire [1:0] mode;
  wire [14:0] ival;
  wire [15:0] thr;
  integer n_errors = 0, comparisons = 0, cycles = 0, i, n;
  // Short millisecond keeps the wake period at a few cycles
  smt_standby_regs #(.MS_CYCLES(4)) uut (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .stopped(stopped), .active_mode(mode),
    .mode_change_indicator(ind), .standby_wake(wake),
    .interval_unit_sec(unit), .standby_interval(ival),
    .standby_current_threshold(thr));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task st;
    @(posedge ref_clk);
    #1;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    st;
    chk("rdata", reg_rdata, e);
  endtask
  task results;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      n_errors = n_errors + 1;
      results;
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    for (i = 10; i < 16; i = i + 1) begin
      rd(i[7:0], i == 11 ? 8'h80 : 8'h00);
    end
    chk("stopped", stopped, 16'h0001);
    $display("reset test done");
    wr(8'h0b, 8'h05);
    wr(8'h0c, 8'ha5);
    wr(8'h0d, 8'h12);
    wr(8'h0e, 8'h34);
    st;
    st;
    chk("unit", unit, 16'h0000);
    chk("interval", ival, 16'h05a5);
    chk("thresh", thr, 16'h1234);
    rd(8'h0e, 8'h34);
    $display("register test done");
    // Every mode, then STOP must hold the last one
    for (i = 0; i < 5; i = i + 1) begin
      wr(8'h0a, i < 4 ? {i[1:0], 6'h01} : 8'h02);
      st;
      st;
      chk("mode", mode, i < 4 ? i[1:0] : 2'b11);
      chk("stopped", stopped, i < 4 ? 16'h0000 : 16'h0001);
    end
    wr(8'h0b, 8'h00);
    wr(8'h0c, 8'h02);
    wr(8'h0a, 8'h83);
    for (i = 0; i < 60 && wake !== 1'b1; i = i + 1) st;
    n = 0;
    do begin
      st;
      n = n + 1;
    end while (wake !== 1'b1 && n < 60);
    chk("wake gap", n[15:0], 16'h0008);
    for (i = 0; i < 2; i = i + 1) begin
      wr(8'h0a, i ? 8'h81 : 8'h03);
      if (i) wr(8'h0a, 8'h01);
      n = 0;
      repeat (10) begin
        st;
        n = n + ind;
      end
      chk("indicator", n[15:0], i ? 16'h0000 : 16'h0001);
    end
    $display("mode test done");
    results;
  end
endmodule // smt_standby_regs_test
bind smt_standby_regs smt_standby_regs_checker chk_i (.ref_clk(ref_clk),
  .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rdata(reg_rdata), .stopped(stopped), .active_mode(active_mode),
  .mode_change_indicator(mode_change_indicator),
  .standby_wake(standby_wake), .interval_unit_sec(interval_unit_sec),
  .standby_interval(standby_interval),
  .standby_current_threshold(standby_current_threshold));
